// ===== hw/codec_pkg.sv
// Behaviour
// R01: Each transmit nibble becomes one 5-bit code group for the serialiser.
// R02: Nibbles 0 to 7 and their code groups map both ways as tabled.
// R03: Nibbles 8 to F and their code groups map both ways as tabled.
// R04: The 16 non-data patterns are control or invalid, never data.
// R05: Idle 11111 fills the line after the end pair while enable is low.
// R06: With the encoder disabled, the group is the raw nibble plus error bit.
// R07: Received 11000 is a start symbol only after idle, else receive error.
// R08: Code 11000 is sent one nibble cycle after transmit enable rises.
// R09: Code 10001 follows as second start symbol; on receive only after J.
// R10: Enable falling sends 01101 then 00111; carrier drops on that pair, after idle during data, or after J without K.
// R11: An invalid code group during receive data valid raises receive error.
// R12: The encoder output is registered, one nibble cycle after its input.
package codec_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int NIBBLE_HZ = 25_000_000;
    localparam int RATE_GCD = 5_000_000;
    // Fractional divider: NIBBLE_STEP ticks out of RATE_MOD cycles
    localparam logic [3:0] NIBBLE_STEP = 4'(NIBBLE_HZ / RATE_GCD);
    localparam logic [3:0] RATE_MOD = 4'(SYS_CLK_HZ / RATE_GCD);
    localparam int FIFO_DEPTH = 8;

    // ==========================================================
    // Code groups
    // ==========================================================
    localparam logic [4:0] CODE_IDLE = 5'h1f; // [R05]
    localparam logic [4:0] CODE_J = 5'h18;
    localparam logic [4:0] CODE_K = 5'h11;
    localparam logic [4:0] CODE_T = 5'h0d;
    localparam logic [4:0] CODE_R = 5'h07;
    localparam logic [4:0] CODE_H = 5'h04;
    localparam logic [3:0] SSD_NIBBLE = 4'h5;

    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] data;
    } tx_mii_t;

    typedef struct packed {
        logic dv;
        logic er;
        logic crs;
        logic [3:0] data;
    } rx_mii_t;

    typedef struct packed {
        logic is_data;
        logic [3:0] nibble;
    } dec_t;

    // ==========================================================
    // Code table
    // ==========================================================
    function automatic logic [4:0] encode_nibble(input logic [3:0] n);
        logic [4:0] c;
        c = CODE_IDLE;
        case (n) // [R02] [R03]
            4'h0: c = 5'h1e;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0a;
            4'h5: c = 5'h0b;
            4'h6: c = 5'h0e;
            4'h7: c = 5'h0f;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'ha: c = 5'h16;
            4'hb: c = 5'h17;
            4'hc: c = 5'h1a;
            4'hd: c = 5'h1b;
            4'he: c = 5'h1c;
            4'hf: c = 5'h1d;
            default: c = CODE_IDLE;
        endcase
        return c;
    endfunction : encode_nibble

    // Inverse by search keeps a single table for both directions
    function automatic dec_t decode_group(input logic [4:0] c);
        dec_t d;
        d = '{is_data: 1'b0, nibble: 4'h0}; // [R04]
        for (int i = 0; i < 16; i++)
        begin
            if (encode_nibble(4'(i)) == c)
            begin
                d.is_data = 1'b1;
                d.nibble = 4'(i);
            end
        end
        return d;
    endfunction : decode_group

endpackage : codec_pkg

// ===== hw/sym_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module sym_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr_q] <= in_data;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end
endmodule : sym_fifo
`default_nettype wire

// ===== hw/fast_ethernet_4b5b_codec.sv
`timescale 1ns/1ps
`default_nettype none
module fast_ethernet_4b5b_codec #(
    parameter int FIFO_DEPTH = codec_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic encode_enable,
    input wire codec_pkg::tx_mii_t tx_mii,
    output logic [4:0] tx_code,
    output logic tx_code_strobe,
    output logic nibble_tick,
    input wire logic [4:0] rx_code,
    input wire logic rx_code_valid,
    output logic rx_code_ready,
    output codec_pkg::rx_mii_t rx_mii,
    output logic rx_strobe
);
    // ==========================================================
    // Nibble rate enable
    // ==========================================================
    // 40 MHz to 25 MHz is not integral: ticks come 5 in 8 cycles
    logic [3:0] acc_q;
    logic [4:0] acc_sum;
    logic tick;

    assign acc_sum = {1'b0, acc_q} + {1'b0, codec_pkg::NIBBLE_STEP};
    assign tick = (acc_sum >= {1'b0, codec_pkg::RATE_MOD});
    assign nibble_tick = tick;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            acc_q <= 4'h0;
        else if (tick)
            acc_q <= 4'(acc_sum - {1'b0, codec_pkg::RATE_MOD});
        else
            acc_q <= acc_sum[3:0];
    end

    // ==========================================================
    // Transmit encoder
    // ==========================================================
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SSD_K = 2'b01,
        TX_DATA = 2'b10,
        TX_ESD_R = 2'b11
    } tx_state_t;

    tx_state_t tx_state_q;
    tx_state_t tx_state_d;
    logic [4:0] tx_code_d;
    logic [4:0] tx_code_q;
    logic tx_strobe_q;

    always_comb
    begin
        tx_state_d = tx_state_q;
        tx_code_d = codec_pkg::CODE_IDLE;
        if (!encode_enable)
        begin
            // Raw path: error bit rides in the fifth position
            tx_state_d = TX_IDLE;
            tx_code_d = {tx_mii.er, tx_mii.data}; // [R06]
        end
        else
        begin
            case (tx_state_q)
                TX_IDLE:
                begin
                    if (tx_mii.en)
                    begin
                        tx_code_d = codec_pkg::CODE_J; // [R08]
                        tx_state_d = TX_SSD_K;
                    end
                    else
                        tx_code_d = codec_pkg::CODE_IDLE; // [R05]
                end
                TX_SSD_K:
                begin
                    tx_code_d = codec_pkg::CODE_K; // [R09]
                    tx_state_d = TX_DATA;
                end
                TX_DATA:
                begin
                    if (!tx_mii.en)
                    begin
                        tx_code_d = codec_pkg::CODE_T; // [R10]
                        tx_state_d = TX_ESD_R;
                    end
                    else if (tx_mii.er)
                        tx_code_d = codec_pkg::CODE_H;
                    else
                        tx_code_d = codec_pkg::encode_nibble(tx_mii.data); // [R01]
                end
                TX_ESD_R:
                begin
                    tx_code_d = codec_pkg::CODE_R; // [R10]
                    tx_state_d = TX_IDLE;
                end
                default:
                begin
                    tx_code_d = codec_pkg::CODE_IDLE;
                    tx_state_d = TX_IDLE;
                end
            endcase
        end
    end

    // Registered so substitutions stay one tick behind their nibble
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_state_q <= TX_IDLE;
            tx_code_q <= codec_pkg::CODE_IDLE;
            tx_strobe_q <= 1'b0;
        end
        else
        begin
            tx_strobe_q <= tick;
            if (tick)
            begin
                tx_state_q <= tx_state_d;
                tx_code_q <= tx_code_d; // [R12]
            end
        end
    end

    assign tx_code = tx_code_q;
    assign tx_code_strobe = tx_strobe_q;

    // ==========================================================
    // Receive buffer
    // ==========================================================
    logic [4:0] fifo_code;
    logic fifo_valid;
    logic fifo_pop;

    // Decoder drains at the nibble rate; a faster source sees ready fall
    assign fifo_pop = tick;

    sym_fifo #(
        .WIDTH(5),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_data(rx_code),
        .in_valid(rx_code_valid),
        .in_ready(rx_code_ready),
        .out_data(fifo_code),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // ==========================================================
    // Receive decoder
    // ==========================================================
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_GOT_J = 2'b01,
        RX_DATA = 2'b10,
        RX_GOT_T = 2'b11
    } rx_state_t;

    rx_state_t rx_state_q;
    rx_state_t rx_state_d;
    codec_pkg::rx_mii_t rx_d;
    codec_pkg::rx_mii_t rx_q;
    codec_pkg::dec_t dec;
    logic rx_strobe_q;

    assign dec = codec_pkg::decode_group(fifo_code);

    always_comb
    begin
        rx_state_d = rx_state_q;
        rx_d = '{dv: 1'b0, er: 1'b0, crs: 1'b0, data: 4'h0};
        case (rx_state_q)
            RX_IDLE:
            begin
                if (fifo_code == codec_pkg::CODE_J) // [R07]
                begin
                    rx_d.crs = 1'b1;
                    rx_d.data = codec_pkg::SSD_NIBBLE;
                    rx_state_d = RX_GOT_J;
                end
            end
            RX_GOT_J:
            begin
                rx_d.crs = 1'b1;
                if (fifo_code == codec_pkg::CODE_K) // [R09]
                begin
                    rx_d.dv = 1'b1;
                    rx_d.data = codec_pkg::SSD_NIBBLE;
                    rx_state_d = RX_DATA;
                end
                else
                begin
                    rx_d.er = 1'b1;
                    rx_state_d = RX_IDLE;
                end
            end
            RX_DATA:
            begin
                rx_d.crs = 1'b1;
                rx_d.dv = 1'b1;
                if (dec.is_data)
                    rx_d.data = dec.nibble; // [R02] [R03]
                else if (fifo_code == codec_pkg::CODE_T)
                    rx_state_d = RX_GOT_T;
                else if (fifo_code == codec_pkg::CODE_IDLE)
                begin
                    // Stream cut without end pair
                    rx_d.er = 1'b1; // [R10]
                    rx_state_d = RX_IDLE;
                end
                else
                    rx_d.er = 1'b1; // [R04] [R07] [R11]
            end
            RX_GOT_T:
            begin
                if (fifo_code == codec_pkg::CODE_R)
                    rx_state_d = RX_IDLE; // [R10]
                else
                begin
                    rx_d.crs = 1'b1;
                    rx_d.dv = 1'b1;
                    rx_d.er = 1'b1; // [R10]
                    rx_state_d = RX_DATA;
                end
            end
            default:
                rx_state_d = RX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_state_q <= RX_IDLE;
            rx_q <= '{dv: 1'b0, er: 1'b0, crs: 1'b0, data: 4'h0};
            rx_strobe_q <= 1'b0;
        end
        else
        begin
            rx_strobe_q <= tick && fifo_valid;
            if (tick && fifo_valid)
            begin
                rx_state_q <= rx_state_d;
                rx_q <= rx_d;
            end
        end
    end

    assign rx_mii = rx_q;
    assign rx_strobe = rx_strobe_q;
endmodule : fast_ethernet_4b5b_codec
`default_nettype wire

// ===== testbench/codec_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module codec_asserts #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic encode_enable,
    input wire codec_pkg::tx_mii_t tx_mii,
    input wire logic [4:0] tx_code,
    input wire logic tx_code_strobe,
    input wire logic nibble_tick,
    input wire logic rx_code_valid,
    input wire logic rx_code_ready,
    input wire codec_pkg::rx_mii_t rx_mii,
    input wire logic rx_strobe
);
    // ========
    // Transmit
    // ========
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    strobe_timing_a:
        assert property (tx_code_strobe == $past(nibble_tick))
        else $error("code strobe misplaced");
    code_hold_a:
        assert property (!tx_code_strobe |-> $stable(tx_code))
        else $error("code moved without strobe");
    idle_fill_a:
        assert property (encode_enable && nibble_tick && !tx_mii.en
            && tx_code == 5'h07 |=> tx_code == 5'h1f)
        else $error("no idle after end pair");
    start_first_a:
        assert property (encode_enable && nibble_tick && tx_mii.en
            && tx_code == 5'h1f |=> tx_code == 5'h18)
        else $error("first start symbol missing");
    start_second_a:
        assert property (encode_enable && nibble_tick
            && tx_code == 5'h18 |=> tx_code == 5'h11)
        else $error("second start symbol missing");
    end_pair_a:
        assert property (encode_enable && nibble_tick
            && tx_code == 5'h0d |=> tx_code == 5'h07)
        else $error("end pair broken");
    bypass_raw_a:
        assert property (!encode_enable && nibble_tick |=>
            tx_code == {$past(tx_mii.er), $past(tx_mii.data)})
        else $error("bypass code wrong");
    // ========
    // Receive
    // ========
    rx_hold_a:
        assert property (!rx_strobe |-> $stable(rx_mii))
        else $error("receive output moved");
    rx_pace_a:
        assert property (rx_strobe |-> $past(nibble_tick))
        else $error("receive strobe off tick");
    rx_latency_a:
        assert property (rx_code_valid && rx_code_ready |->
            ##[2:40] rx_strobe)
        else $error("receive answer late");

    cover property (nibble_tick && tx_mii.en && tx_code == 5'h1f);
    cover property (rx_strobe && rx_mii.er);
    cover property (rx_code_valid && !rx_code_ready);
endmodule : codec_asserts

bind fast_ethernet_4b5b_codec codec_asserts #(.FIFO_DEPTH(FIFO_DEPTH))
    chk (.sys_clk(sys_clk), .reset(reset), .encode_enable(encode_enable),
    .tx_mii(tx_mii), .tx_code(tx_code), .tx_code_strobe(tx_code_strobe),
    .nibble_tick(nibble_tick), .rx_code_valid(rx_code_valid),
    .rx_code_ready(rx_code_ready), .rx_mii(rx_mii), .rx_strobe(rx_strobe));
`default_nettype wire

// ===== testbench/mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module mac_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic nibble_tick,
    input wire logic start,
    input wire logic [4:0] frame_len,
    input wire logic [4:0] er_pos,
    output codec_pkg::tx_mii_t tx_mii,
    output logic busy
);
    logic [4:0] cnt_q;
    // ========
    // Frame driver
    // ========
    // Moves only after a tick edge, so each nibble is steady when sampled
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_mii <= '0;
            busy <= 1'b0;
            cnt_q <= 5'h00;
        end
        else if (nibble_tick)
        begin
            tx_mii <= '0;
            if (!busy)
            begin
                busy <= start;
                cnt_q <= 5'h00;
            end
            else if (cnt_q == frame_len + 5'h02)
                busy <= 1'b0;
            else
            begin
                tx_mii.en <= 1'b1;
                tx_mii.er <= (cnt_q == er_pos);
                tx_mii.data <= (cnt_q < 5'h02) ? 4'h5 : 4'(cnt_q - 5'h02);
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end
endmodule : mac_model
`default_nettype wire

// ===== testbench/fast_ethernet_4b5b_codec_test.sv
`timescale 1ns/1ps
`default_nettype none
module fast_ethernet_4b5b_codec_test;
    localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a,
        5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b,
        5'h1c, 5'h1d};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic encode_enable = 1'b1;
    logic start = 1'b0;
    logic [4:0] frame_len = 5'h00;
    logic [4:0] er_pos = 5'h1f;
    logic [4:0] rx_code = 5'h1f;
    logic rx_code_valid = 1'b0;
    logic full_seen = 1'b0;
    logic [4:0] tx_code;
    logic tx_code_strobe, nibble_tick, rx_code_ready, rx_strobe, busy;
    codec_pkg::tx_mii_t tx_mii;
    codec_pkg::rx_mii_t rx_mii;
    logic [6:0] txq[$];
    logic [6:0] rxq[$];
    int fails = 0;
    int total_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    fast_ethernet_4b5b_codec dut (.sys_clk(sys_clk), .reset(reset),
        .encode_enable(encode_enable), .tx_mii(tx_mii), .tx_code(tx_code),
        .tx_code_strobe(tx_code_strobe), .nibble_tick(nibble_tick),
        .rx_code(rx_code), .rx_code_valid(rx_code_valid),
        .rx_code_ready(rx_code_ready), .rx_mii(rx_mii),
        .rx_strobe(rx_strobe));
    mac_model mac (.sys_clk(sys_clk), .reset(reset),
        .nibble_tick(nibble_tick), .start(start), .frame_len(frame_len),
        .er_pos(er_pos), .tx_mii(tx_mii), .busy(busy));

    // ========
    // Monitor
    // ========
    // Mid-cycle sampling keeps clear of the outputs' own edge
    always @(negedge sys_clk)
    begin
        if (tx_code_strobe)
            txq.push_back(7'(tx_code));
        if (rx_strobe)
            rxq.push_back(rx_mii);
        if (rx_code_ready === 1'b0)
            full_seen = 1'b1;
    end

    task automatic check(string what, logic [6:0] seen, logic [6:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic match(string what, logic [6:0] q[$], logic [6:0] e[$],
        logic [6:0] m);
        int k = 0;
        while (k < q.size() && q[k] !== e[0])
            k++;
        foreach (e[i])
            check(what, q[k + i] & m, e[i] & m);
    endtask : match

    task automatic wait_busy(input logic v);
        for (int n = 0; n < 200 && busy !== v; n++)
            @(negedge sys_clk);
        // A stuck model must not pass quietly
        if (busy !== v)
            fails++;
    endtask : wait_busy

    task automatic run_tx(input logic [4:0] len, input logic [4:0] pos);
        txq.delete();
        frame_len <= len;
        er_pos <= pos;
        start <= 1'b1;
        wait_busy(1'b1);
        @(posedge sys_clk);
        start <= 1'b0;
        wait_busy(1'b0);
        repeat (40) @(posedge sys_clk);
    endtask : run_tx

    task automatic push(input logic [4:0] c);
        rx_code <= c;
        rx_code_valid <= 1'b1;
        @(negedge sys_clk);
        for (int n = 0; n < 50 && rx_code_ready !== 1'b1; n++)
            @(negedge sys_clk);
        if (rx_code_ready !== 1'b1)
            fails++;
        @(posedge sys_clk);
    endtask : push

    task automatic run_rx(input logic [4:0] c[$]);
        @(posedge sys_clk);
        rxq.delete();
        foreach (c[i])
            push(c[i]);
        rx_code_valid <= 1'b0;
        rx_code <= ~rx_code;
        repeat (40) @(posedge sys_clk);
    endtask : run_rx

    // ========
    // Scenarios
    // ========
    task automatic test_encode();
        logic [6:0] e[$];
        e = '{7'h18, 7'h11};
        for (int i = 0; i < 16; i++)
            e.push_back(i == 9 ? 7'h04 : 7'(ENC[i]));
        e = {e, 7'h0d, 7'h07, 7'h1f};
        run_tx(5'h10, 5'h0b);
        match("tx code", txq, e, 7'h7f);
    endtask : test_encode

    task automatic test_bypass();
        encode_enable <= 1'b0;
        run_tx(5'h04, 5'h03);
        match("bypass", txq, '{7'h05, 7'h05, 7'h00, 7'h11, 7'h02, 7'h03,
            7'h00}, 7'h7f);
        encode_enable <= 1'b1;
    endtask : test_bypass

    task automatic test_rx();
        logic [4:0] c[$];
        logic [6:0] e[$];
        c = '{5'h18, 5'h11};
        e = '{7'h15, 7'h55};
        for (int i = 0; i < 16; i++)
        begin
            c.push_back(ENC[i]);
            e.push_back(7'h50 | 7'(i));
        end
        c = {c, 5'h0d, 5'h07, 5'h1f};
        e = {e, 7'h50, 7'h00, 7'h00};
        repeat (30) c.push_front(5'h1f);
        run_rx(c);
        match("rx nibble", rxq, e, 7'h7f);
        check("fifo full", 7'(full_seen), 7'h01);
    endtask : test_rx

    task automatic test_rx_errors();
        run_rx('{5'h18, 5'h18, 5'h18, 5'h11, 5'h06, 5'h19, 5'h01, 5'h18,
            5'h0d, 5'h00, 5'h1f, 5'h11});
        match("rx error", rxq, '{7'h15, 7'h20, 7'h15, 7'h55, 7'h20, 7'h20,
            7'h20, 7'h20, 7'h50, 7'h20, 7'h20, 7'h00}, 7'h20);
    endtask : test_rx_errors

    task automatic conclude();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fails++;
        conclude();
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        test_encode();
        test_bypass();
        test_rx();
        test_rx_errors();
        conclude();
    end
endmodule : fast_ethernet_4b5b_codec_test
`default_nettype wire
